/* File: rb_defs.svh */
// constants for the readback verify and capture pair: offsets, field positions, reset values, sizes
// assumes one 10 MHz system clock shared by both ends
`ifndef RB_DEFS_SVH
`define RB_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define FRAME_BITS 32
`define NUM_FRAMES 4
`define STREAM_BITS 160
`define MEM_BYTES 20
`define USER_W 8
`define IDX_W 8

// ----------------------------------------------------------------
// configuration memory layout and reset values
// ----------------------------------------------------------------
`define CAP_FRAME 2
`define CAP_BIT 4
`define CFG_INIT_WORD 32'h5a5a_a5a5
`define PAD_BIT 1'b0

// ----------------------------------------------------------------
// checker register offsets (byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_IRQ_STAT 5'h08
`define REG_IRQ_MASK 5'h0c
`define REG_FAIL 5'h10
`define REG_TEXT 5'h14
`define REG_LOAD 5'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_START 0
`define CTRL_MODE 1
`define CTRL_CAPTURE 2
`define CTRL_RESTORE 3
`define TEXT_SEL_MASK 8
`define IRQ_DONE 0
`define IRQ_MISMATCH 1
`define CHAR_ZERO 8'h30
`define CHAR_ONE 8'h31
`define CHAR_NL 8'h0a

`endif

/* File: rb_pkg.sv */
// types shared by the device end and the checker end
// assumes rb_defs.svh carries all numeric constants
`default_nettype none

package rb_pkg;

	// ----------------------------------------------------------------
	// state machines, gray coded from idle through run to finish
	// ----------------------------------------------------------------
	typedef enum logic {
		DEV_IDLE = 1'b0,
		DEV_STREAM = 1'b1
	} dev_state_e;

	typedef enum logic [1:0] {
		CHK_IDLE = 2'b00,
		CHK_RUN = 2'b01,
		CHK_FINISH = 2'b11
	} chk_state_e;

	typedef enum logic {
		MODE_GOLDEN = 1'b0,
		MODE_BITSTREAM = 1'b1
	} cmp_mode_e;

endpackage

`default_nettype wire

/* File: readback_link_if.sv */
// link between the checker end and the device end
// assumes both ends run on the same clock; all signals come from flops
`timescale 1ns/1ps
`default_nettype none

interface readback_link_if;
	logic rb_start;
	logic capture_command;
	logic restore_command;
	logic rb_valid;
	logic rb_bit;
	logic rb_last;

	modport dev (
		input rb_start,
		input capture_command,
		input restore_command,
		output rb_valid,
		output rb_bit,
		output rb_last
	);

	modport chk (
		output rb_start,
		output capture_command,
		output restore_command,
		input rb_valid,
		input rb_bit,
		input rb_last
	);
endinterface

`default_nettype wire

/* File: mask_compare.sv */
// one-bit masked comparator with registered result
// assumes the caller presents expected and mask bits aligned to the stream bit
`timescale 1ns/1ps
`default_nettype none
`include "rb_defs.svh"

module mask_compare (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// bit under test
	input wire logic en,
	input wire logic rb_bit,
	input wire logic exp_bit,
	input wire logic mask_bit,
	input wire logic [`IDX_W-1:0] pos,
	// result
	output logic mism_q,
	output logic [`IDX_W-1:0] pos_q
);
	// a set mask bit makes the position a don't-care
	wire logic mism_d = en & ~mask_bit & (rb_bit ^ exp_bit);

	// result stands one cycle after the bit
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mism_q <= 1'b0;
			pos_q <= '0;
		end else begin
			mism_q <= mism_d;
			pos_q <= pos;
		end
	end
endmodule // mask_compare

`default_nettype wire

/* File: readback_device.sv */
// device end: configuration memory, register capture and readback stream
// assumes the capture request comes from user logic on SYS_CLK, which doubles as capture clock
`timescale 1ns/1ps
`default_nettype none
`include "rb_defs.svh"

module readback_device (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	// link to checker
	readback_link_if.dev LINK,
	// user design side
	input wire logic CAPTURE_REQUEST,
	input wire logic SINGLE_SHOT_OPTION,
	input wire logic [`USER_W-1:0] USER_REGS,
	output logic CAPTURE_GRAB_STROBE,
	output logic RESTORE_PULSE,
	output logic [`USER_W-1:0] RESTORE_VALUE
);
	// ----------------------------------------------------------------
	// capture
	// ----------------------------------------------------------------
	logic [`FRAME_BITS-1:0] cfg_q [0:`NUM_FRAMES-1];
	logic req_prev_q;
	logic grab_q;
	logic restore_q;
	logic [`USER_W-1:0] restore_val_q;

	// single-shot blocks every edge after the first while the request stays high
	wire logic grab_user = CAPTURE_REQUEST & (~SINGLE_SHOT_OPTION | ~req_prev_q);
	wire logic grab = grab_user | LINK.capture_command;
	wire logic [`USER_W-1:0] cell_val = cfg_q[`CAP_FRAME][`CAP_BIT +: `USER_W];

	// capture lands in the initial-state cell, so a later restore brings back the grabbed values
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			for (int i = 0; i < `NUM_FRAMES; i++) begin
				cfg_q[i] <= `CFG_INIT_WORD;
			end
			req_prev_q <= 1'b0;
			grab_q <= 1'b0;
			restore_q <= 1'b0;
			restore_val_q <= '0;
		end else begin
			req_prev_q <= CAPTURE_REQUEST;
			grab_q <= grab;
			if (grab) begin
				cfg_q[`CAP_FRAME][`CAP_BIT +: `USER_W] <= ~USER_REGS;
			end
			restore_q <= LINK.restore_command;
			if (LINK.restore_command) begin
				restore_val_q <= ~cell_val;
			end
		end
	end

	assign CAPTURE_GRAB_STROBE = grab_q;
	assign RESTORE_PULSE = restore_q;
	assign RESTORE_VALUE = restore_val_q;

	// ----------------------------------------------------------------
	// readback stream
	// ----------------------------------------------------------------
	rb_pkg::dev_state_e state_q;
	logic [`IDX_W-1:0] idx_q;
	logic valid_q;
	logic bit_q;
	logic last_q;

	// data bits carry no header and feed no checksum; the first frame is pure pad
	wire logic in_pad = idx_q < `IDX_W'(`FRAME_BITS);
	wire logic [`IDX_W-1:0] cfg_pos = idx_q - `IDX_W'(`FRAME_BITS);
	wire logic cfg_bit = cfg_q[cfg_pos[6:5]][cfg_pos[4:0]];
	wire logic at_end = idx_q == `IDX_W'(`STREAM_BITS - 1);

	// one bit per clock from start to end, start ignored while streaming
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			state_q <= rb_pkg::DEV_IDLE;
			idx_q <= '0;
			valid_q <= 1'b0;
			bit_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			case (state_q)
				rb_pkg::DEV_IDLE: begin
					valid_q <= 1'b0;
					last_q <= 1'b0;
					idx_q <= '0;
					if (LINK.rb_start) begin
						state_q <= rb_pkg::DEV_STREAM;
					end
				end
				rb_pkg::DEV_STREAM: begin
					valid_q <= 1'b1;
					bit_q <= in_pad ? `PAD_BIT : cfg_bit;
					last_q <= at_end;
					idx_q <= idx_q + 1'b1;
					if (at_end) begin
						state_q <= rb_pkg::DEV_IDLE;
					end
				end
				default: state_q <= rb_pkg::DEV_IDLE;
			endcase
		end
	end

	assign LINK.rb_valid = valid_q;
	assign LINK.rb_bit = bit_q;
	assign LINK.rb_last = last_q;
endmodule // readback_device

`default_nettype wire

/* File: readback_checker.sv */
// checker end: loads expected and mask data as text, drives readback, compares with masking
// assumes software on Avalon-MM with waitrequest; one access answered per two cycles
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rb_defs.svh"

module readback_checker (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	// avalon-mm slave
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// interrupt
	output logic IRQ,
	// link to device
	readback_link_if.chk LINK
);
	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic wait_q;
	logic [31:0] rdata_q;
	wire logic req = AVS_READ | AVS_WRITE;
	// first cycle of a request only loads read data; the access completes in the second
	wire logic acc = req & ~wait_q;
	wire logic wr = acc & AVS_WRITE;
	wire logic wr_ctrl = wr & (AVS_ADDRESS == `REG_CTRL);
	wire logic wr_stat = wr & (AVS_ADDRESS == `REG_IRQ_STAT);
	wire logic wr_mask = wr & (AVS_ADDRESS == `REG_IRQ_MASK);
	wire logic wr_text = wr & (AVS_ADDRESS == `REG_TEXT);
	wire logic wr_load = wr & (AVS_ADDRESS == `REG_LOAD);

	rb_pkg::chk_state_e state_q;
	rb_pkg::cmp_mode_e mode_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic seen_mism_q;
	logic [`IDX_W-1:0] fail_q;
	logic [`IDX_W-1:0] ptr_q;

	// reported offset counts from frame address zero, past the pad frame
	wire logic [`IDX_W-1:0] fail_off = fail_q - `IDX_W'(`FRAME_BITS);
	wire logic fail_in_pad = seen_mism_q & (fail_q < `IDX_W'(`FRAME_BITS)); // no fail recorded reads as not in pad
	wire logic busy = state_q != rb_pkg::CHK_IDLE;

	// read mux, unmapped addresses read zero
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0000_0000;
		if (AVS_ADDRESS == `REG_CTRL) begin
			rmux = {30'h0, mode_q, 1'b0};
		end else if (AVS_ADDRESS == `REG_STATUS) begin
			rmux = {29'h0, fail_in_pad, seen_mism_q, busy};
		end else if (AVS_ADDRESS == `REG_IRQ_STAT) begin
			rmux = {30'h0, irq_stat_q};
		end else if (AVS_ADDRESS == `REG_IRQ_MASK) begin
			rmux = {30'h0, irq_mask_q};
		end else if (AVS_ADDRESS == `REG_FAIL) begin
			rmux = {8'h00, fail_q, 1'b0, fail_off[6:5], fail_off[4:0], fail_off};
		end else if (AVS_ADDRESS == `REG_LOAD) begin
			rmux = {24'h00_0000, ptr_q};
		end
	end

	// waitrequest high by default, low for exactly one cycle per access
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= ~(req & wait_q);
			if (AVS_READ & wait_q) begin
				rdata_q <= rmux;
			end
		end
	end

	assign AVS_WAITREQUEST = wait_q;
	assign AVS_READDATA = rdata_q;

	// ----------------------------------------------------------------
	// text loader for expected and mask memories
	// ----------------------------------------------------------------
	logic [7:0] exp_mem [0:`MEM_BYTES-1];
	logic [7:0] msk_mem [0:`MEM_BYTES-1];
	logic sol_q;
	logic data_line_q;
	logic [7:0] sh_q;
	logic [2:0] cnt_q;

	wire logic [7:0] ch = AVS_WRITEDATA[7:0];
	wire logic is_bin = (ch == `CHAR_ZERO) | (ch == `CHAR_ONE);
	wire logic is_nl = ch == `CHAR_NL;
	// header lines never start with a binary digit, so a whole line is skipped on its first char
	wire logic take = wr_text & ~is_nl & is_bin & (sol_q | data_line_q);
	wire logic [7:0] sh_d = {sh_q[6:0], ch[0]};
	wire logic byte_done = take & (cnt_q == 3'h7) & (ptr_q < `IDX_W'(`MEM_BYTES));

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			sol_q <= 1'b1;
			data_line_q <= 1'b0;
			sh_q <= 8'h00;
			cnt_q <= 3'h0;
			ptr_q <= '0;
		end else if (wr_load) begin
			sol_q <= 1'b1;
			data_line_q <= 1'b0;
			cnt_q <= 3'h0;
			ptr_q <= '0;
		end else if (wr_text) begin
			sol_q <= is_nl;
			if (is_nl) begin
				data_line_q <= 1'b0;
			end else if (sol_q) begin
				data_line_q <= is_bin;
			end
			if (take) begin
				sh_q <= sh_d;
				cnt_q <= cnt_q + 1'b1;
			end
			if (byte_done) begin
				ptr_q <= ptr_q + 1'b1;
			end
		end
	end

	// memories have no reset; software loads them before a run
	always_ff @(posedge SYS_CLK) begin
		if (byte_done & ~AVS_WRITEDATA[`TEXT_SEL_MASK]) begin
			exp_mem[ptr_q[4:0]] <= sh_d;
		end
		if (byte_done & AVS_WRITEDATA[`TEXT_SEL_MASK]) begin
			msk_mem[ptr_q[4:0]] <= sh_d;
		end
	end

	// ----------------------------------------------------------------
	// readback run and compare
	// ----------------------------------------------------------------
	logic [`IDX_W-1:0] idx_q;
	logic start_q;
	logic cap_q;
	logic rst_q;

	// golden data holds the pad frame too; bitstream payload starts after it
	wire logic bs_mode = mode_q == rb_pkg::MODE_BITSTREAM;
	wire logic [`IDX_W-1:0] mem_idx = bs_mode ? idx_q - `IDX_W'(`FRAME_BITS) : idx_q;
	wire logic in_range = ~(bs_mode & (idx_q < `IDX_W'(`FRAME_BITS))) & (mem_idx < `IDX_W'(`STREAM_BITS));
	wire logic cmp_en = (state_q == rb_pkg::CHK_RUN) & LINK.rb_valid & in_range;
	wire logic exp_bit = exp_mem[mem_idx[7:3]][3'h7 - mem_idx[2:0]];
	wire logic msk_bit = msk_mem[mem_idx[7:3]][3'h7 - mem_idx[2:0]];
	wire logic mism;
	wire logic [`IDX_W-1:0] mism_pos;
	wire logic done_ev = state_q == rb_pkg::CHK_FINISH;

	mask_compare u_cmp (
		.clk(SYS_CLK),
		.nrst(NRST),
		.en(cmp_en),
		.rb_bit(LINK.rb_bit),
		.exp_bit(exp_bit),
		.mask_bit(msk_bit),
		.pos(idx_q),
		.mism_q(mism),
		.pos_q(mism_pos)
	);

	// finish waits one cycle so the last bit's compare result is in
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			state_q <= rb_pkg::CHK_IDLE;
			mode_q <= rb_pkg::MODE_GOLDEN;
			idx_q <= '0;
			start_q <= 1'b0;
			cap_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			cap_q <= wr_ctrl & AVS_WRITEDATA[`CTRL_CAPTURE];
			rst_q <= wr_ctrl & AVS_WRITEDATA[`CTRL_RESTORE];
			case (state_q)
				rb_pkg::CHK_IDLE: begin
					if (wr_ctrl) begin
						mode_q <= rb_pkg::cmp_mode_e'(AVS_WRITEDATA[`CTRL_MODE]);
					end
					if (wr_ctrl & AVS_WRITEDATA[`CTRL_START]) begin
						start_q <= 1'b1;
						idx_q <= '0;
						state_q <= rb_pkg::CHK_RUN;
					end
				end
				rb_pkg::CHK_RUN: begin
					if (LINK.rb_valid) begin
						idx_q <= idx_q + 1'b1;
					end
					if (LINK.rb_valid & LINK.rb_last) begin
						state_q <= rb_pkg::CHK_FINISH;
					end
				end
				rb_pkg::CHK_FINISH: state_q <= rb_pkg::CHK_IDLE;
				default: state_q <= rb_pkg::CHK_IDLE;
			endcase
		end
	end

	assign LINK.rb_start = start_q;
	assign LINK.capture_command = cap_q;
	assign LINK.restore_command = rst_q;

	// ----------------------------------------------------------------
	// mismatch record and interrupts
	// ----------------------------------------------------------------
	// a new event wins over a write-one-to-clear in the same cycle
	wire logic [1:0] irq_set = {mism, done_ev};
	wire logic [1:0] irq_clr = wr_stat ? AVS_WRITEDATA[1:0] : 2'b00;
	wire logic run_start = start_q;

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			irq_stat_q <= 2'b00;
			irq_mask_q <= 2'b00;
			seen_mism_q <= 1'b0;
			fail_q <= '0;
			IRQ <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
			if (wr_mask) begin
				irq_mask_q <= AVS_WRITEDATA[1:0];
			end
			if (run_start) begin
				seen_mism_q <= 1'b0;
			end else if (mism) begin
				seen_mism_q <= 1'b1;
			end
			if (mism & ~seen_mism_q) begin
				fail_q <= mism_pos;
			end
			IRQ <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
		end
	end
endmodule // readback_checker

`default_nettype wire

/* File: readback_link_sva.sv */
// concurrent checks on the link between the checker end and the device end
// assumes the bench instantiates it beside the link, on the single clock SYS_CLK
`timescale 1ns/1ps
`default_nettype none

module readback_link_sva (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	// checker to device
	input wire logic rb_start,
	input wire logic capture_command,
	input wire logic restore_command,
	// device to checker
	input wire logic rb_valid,
	input wire logic rb_bit,
	input wire logic rb_last
);
	logic active_q;
	logic active_d;
	logic [7:0] idx_q;
	logic [7:0] idx_d;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!NRST);

	// ----
	// stream tracking
	// ----
	// a start while active is ignored, so only the first start opens a stream
	assign active_d = rb_last ? 1'b0 : (rb_start | active_q);
	assign idx_d = rb_last ? 8'h00 : (rb_valid ? idx_q + 8'h01 : idx_q);

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			active_q <= 1'b0;
			idx_q <= 8'h00;
		end else begin
			active_q <= active_d;
			idx_q <= idx_d;
		end
	end

	// ----
	// assertions
	// ----
	start_answer_a: assert property (rb_start && !active_q |-> ##2 rb_valid)
		else $error("stream did not start two cycles after start");
	pad_zero_a: assert property (rb_valid && idx_q < 8'd32 |-> !rb_bit)
		else $error("pad frame bit is not zero");
	last_count_a: assert property (rb_last |-> rb_valid && idx_q == 8'd159)
		else $error("last bit not at stream index 159");
	run_gapless_a: assert property (rb_valid && !rb_last |=> rb_valid)
		else $error("gap inside readback stream");
	last_close_a: assert property (rb_last |=> !rb_valid)
		else $error("stream continues after last bit");
	valid_framed_a: assert property (rb_valid |-> active_q)
		else $error("stream bit without a start");
	start_pulse_a: assert property (rb_start |=> !rb_start)
		else $error("start longer than one cycle");
	command_pulse_a: assert property (capture_command || restore_command |=> !capture_command && !restore_command)
		else $error("command longer than one cycle");
endmodule // readback_link_sva

`default_nettype wire

/* File: readback_verify_capture_tb.sv */
// self-checking bench for the checker end and device end joined by the link
// assumes each Avalon access is answered after one wait cycle and a stream is 160 bits
`timescale 1ns/1ps
`default_nettype none
`include "rb_defs.svh"

module readback_verify_capture_tb;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, irq, grab, rst_pulse;
	logic cap_req = 1'b0;
	logic single_shot = 1'b0;
	logic [7:0] user_regs = 8'h00;
	logic [7:0] rst_value;
	logic [159:0] got_q, exp0;
	logic [31:0] cfg [4];
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;
	int vcnt = 0;
	int n_grab = 0;
	int n_rst = 0;
	int base;

	readback_link_if link ();
	readback_checker u_readback_checker (.SYS_CLK(sys_clk), .NRST(nrst), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq), .LINK(link));
	readback_device u_readback_device (.SYS_CLK(sys_clk), .NRST(nrst), .LINK(link), .CAPTURE_REQUEST(cap_req),
		.SINGLE_SHOT_OPTION(single_shot), .USER_REGS(user_regs), .CAPTURE_GRAB_STROBE(grab),
		.RESTORE_PULSE(rst_pulse), .RESTORE_VALUE(rst_value));
	readback_link_sva u_readback_link_sva (.SYS_CLK(sys_clk), .NRST(nrst), .rb_start(link.rb_start),
		.capture_command(link.capture_command), .restore_command(link.restore_command),
		.rb_valid(link.rb_valid), .rb_bit(link.rb_bit), .rb_last(link.rb_last));

	always #50 sys_clk = ~sys_clk;

	// ----
	// watchdog, stream capture and pulse counters
	// ----
	// bits shift in from the top so bit i of the stream lands at index i
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (link.rb_start === 1'b1) vcnt <= 0;
		else if (link.rb_valid === 1'b1) vcnt <= vcnt + 1;
		if (link.rb_valid === 1'b1) got_q <= {link.rb_bit, got_q[159:1]};
		if (grab === 1'b1) n_grab <= n_grab + 1;
		if (rst_pulse === 1'b1) n_rst <= n_rst + 1;
		if (cycles == 20000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (n_fail == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_stream(input logic [159:0] got, input logic [159:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one access held until waitrequest is sampled low; read data taken at that edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// irq follows its mask one cycle late, so two edges settle it
	task automatic chk_irq(input logic e);
		repeat (2) @(posedge sys_clk);
		chk_word({31'h0, irq}, {31'h0, e});
	endtask

	function automatic logic [159:0] stream_of();
		logic [159:0] s;
		s = '0;
		for (int f = 0; f < 4; f++) s[32 + 32 * f +: 32] = cfg[f];
		return s;
	endfunction

	// header line first, then one character per bit
	task automatic load(input logic [159:0] b, input logic sel, input int n);
		bus(1'b1, `REG_LOAD, 32'h0);
		bus(1'b1, `REG_TEXT, {23'h0, sel, 8'h68});
		bus(1'b1, `REG_TEXT, {23'h0, sel, `CHAR_NL});
		for (int i = 0; i < n; i++) begin
			bus(1'b1, `REG_TEXT, {23'h0, sel, b[i] ? `CHAR_ONE : `CHAR_ZERO});
		end
	endtask

	// st is the expected status word: b1 mismatch seen, b2 first fail in pad
	task automatic run(input logic mode, input logic [2:0] st, input logic [159:0] exp_s);
		bus(1'b1, `REG_IRQ_STAT, 32'h3);
		bus(1'b1, `REG_CTRL, {30'h0, mode, 1'b1});
		while (irq !== 1'b1) @(posedge sys_clk);
		bus(1'b0, `REG_STATUS, 32'h0);
		chk_word(rd, {29'h0, st});
		chk_stream(got_q, exp_s);
		chk_word(vcnt, 32'd160);
	endtask

	task automatic capture(input logic ss, input logic [7:0] a, b, c, input int n);
		base = n_grab;
		@(posedge sys_clk);
		single_shot <= ss;
		cap_req <= 1'b1;
		user_regs <= a;
		@(posedge sys_clk);
		user_regs <= b;
		@(posedge sys_clk);
		user_regs <= c;
		@(posedge sys_clk);
		cap_req <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk_word(n_grab - base, n);
	endtask

	// restore hands back the complement of the capture cell one edge after the command
	task automatic restore_chk(input logic [7:0] v);
		base = n_rst;
		bus(1'b1, `REG_CTRL, 32'h8);
		repeat (4) @(posedge sys_clk);
		chk_word(n_rst - base, 32'd1);
		chk_word({24'h0, rst_value}, {24'h0, v});
	endtask

	// ----
	// main sequence
	// ----
	initial begin
		for (int f = 0; f < 4; f++) cfg[f] = `CFG_INIT_WORD;
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		bus(1'b0, 5'h1c, 32'h0);
		chk_word(rd, 32'h0);
		chk_word({24'h0, rst_value}, 32'h0);
		bus(1'b0, `REG_STATUS, 32'h0);
		chk_word(rd, 32'h0);
		bus(1'b1, `REG_IRQ_MASK, 32'h1);
		exp0 = stream_of();
		load(exp0, 1'b0, 160);
		load('0, 1'b1, 160);
		run(1'b0, 3'h0, exp0);
		capture(1'b1, 8'h3c, 8'h77, 8'h88, 1);
		restore_chk(8'h3c);
		capture(1'b0, 8'h11, 8'h22, 8'ha5, 3);
		restore_chk(8'ha5);
		// a fresh value shows that the command capture really rewrites the cell
		user_regs <= 8'h96;
		base = n_grab;
		bus(1'b1, `REG_CTRL, 32'h4);
		repeat (4) @(posedge sys_clk);
		chk_word(n_grab - base, 32'd1);
		cfg[2][11:4] = ~8'h96;
		restore_chk(8'h96);
		run(1'b0, 3'h2, stream_of());
		bus(1'b0, `REG_FAIL, 32'h0);
		chk_word(rd, 32'h0064_4444);
		bus(1'b0, `REG_IRQ_STAT, 32'h0);
		chk_word(rd, 32'h3);
		bus(1'b1, `REG_IRQ_MASK, 32'h0);
		chk_irq(1'b0);
		bus(1'b1, `REG_IRQ_MASK, 32'h2);
		chk_irq(1'b1);
		bus(1'b1, `REG_IRQ_STAT, 32'h2);
		chk_irq(1'b0);
		bus(1'b1, `REG_IRQ_MASK, 32'h1);
		load(160'hff << 100, 1'b1, 160);
		run(1'b0, 3'h0, stream_of());
		load(stream_of() >> 32, 1'b0, 128);
		load('0, 1'b1, 128);
		run(1'b1, 3'h0, stream_of());
		// one flipped pad bit in the golden data must be caught and flagged as lying in the pad
		load(stream_of() ^ 160'h1, 1'b0, 160);
		run(1'b0, 3'h6, stream_of());
		give_verdict();
	end
endmodule // readback_verify_capture_tb

`default_nettype wire
